// [verilog/pin_mux_consts.svh]
// constants for the port pin mux and data block
// assumes byte addresses on a 32-bit classic wishbone bus
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// =====================================================
// register byte addresses
`define ADDR_PORTA_DATA     32'hFFFF_FC84
`define ADDR_PORTB_SELECT   32'hFFFF_FC90
`define ADDR_PORTB_DIR      32'hFFFF_FC94
`define ADDR_PORTA_DIR      32'hFFFF_FC98

// =====================================================
// reset values, power-on only
`define RST_PORTA_DATA      16'h0000
`define RST_PORTB_SELECT    16'h0000
`define RST_PORTB_DIR       16'h0000
`define RST_PORTA_DIR       16'h0000

// =====================================================
// port a data: bits 15, 14 and 3 hold no storage
`define PORTA_DATA_MASK     16'h3FF7
`define PORTA_CLK_PIN       3

// =====================================================
// port b selector field low bit positions
`define SEL_PIN0_LSB        0
`define SEL_PIN1_LSB        2
`define SEL_PIN2_LSB        4
`define SEL_PIN3_LSB        6
`define SEL_PIN4_LSB        8
`define SEL_PIN5_LSB        10

`endif

// [verilog/pin_mux_pkg.sv]
// types for the port pin mux and data block
// assumes pin_mux_consts.svh supplies the numbers
package pin_mux_pkg;

   // =====================================================
   // two-bit pin function selector codes
   typedef enum logic [1:0] {
      MODE_GPIO = 2'b00,
      MODE_ALT1 = 2'b01,
      MODE_ALT2 = 2'b10,
      MODE_ALT3 = 2'b11
   } pin_mode_e;

   typedef logic [15:0] reg16_t;

endpackage

// [verilog/port_pin_mux_and_data.sv]
// port a data register, port b low pin function select and
// port b direction, reached over a classic wishbone slave
// assumes pins and peripheral signals are synchronous to mclk_in
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"

// Operation
// - pin5 select: 00 gpio, 01 reserved, 10 serial1 rx sync, 11 uart2 rx
// - pin4 select: 00 gpio, 01 reserved, 10 serial1 rx data, 11 uart2 tx
// - pin3 select: 00 gpio, 01 reserved, 10 serial1 tx clock, 11 timer0 a
// - pin2 select: 00 gpio, 01 reserved, 10 serial1 tx sync, 11 timer0 b
// - pin1 select: 00 gpio, 01 reserved, 10 serial1 tx data, 11 timer0 c
// - pin0 select: 00 gpio, 01 wake-on-lan out, 10 reserved, 11 timer0 d
// - port b direction: 16 bits, 1 output, 0 input
// - direction bit acts only while pin is general i/o
// - port b direction cleared only by power-on reset
// - port a has 14 pins, port b 16, shared with other functions
// - port a clock output pin has no data storage bit
// - port a data bits 15, 14, 3 read zero; software writes zero
// - general output: write drives pin, read returns stored bit
// - general input: read returns pin, write only stores
// - other function: read pin if direction 0, stored bit if 1
// - port a data cleared only by power-on reset
// - port a data at 0xfffffc84, byte and halfword access
module port_pin_mux_and_data (
   // clock and power-on reset
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   // wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [31:0] wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   // port a pins
   input  wire logic [13:0] porta_pin_in,
   output logic      [13:0] porta_pin_out,
   output logic      [13:0] porta_pin_oe_out,
   // port a peripheral side
   input  wire logic [13:0] porta_func_in,
   input  wire logic [13:0] porta_periph_in,
   input  wire logic [13:0] porta_periph_oe_in,
   input  wire logic        internal_clock_out_pin_in,
   output logic      [13:0] porta_periph_out,
   // port b pins
   input  wire logic [15:0] portb_pin_in,
   output logic      [15:0] portb_pin_out,
   output logic      [15:0] portb_pin_oe_out,
   // port b general output data, stored elsewhere
   input  wire logic [15:0] portb_data_in,
   // serial unit 1
   output logic             serial1_rx_sync_out,
   output logic             serial1_rx_data_out,
   output logic             serial1_tx_clock_out,
   input  wire logic        serial1_tx_sync_in,
   input  wire logic        serial1_tx_sync_oe_in,
   output logic             serial1_tx_sync_out,
   input  wire logic        serial1_tx_data_in,
   // uart unit 2
   output logic             uart2_rx_out,
   input  wire logic        uart2_tx_in,
   // network controller
   input  wire logic        wake_on_lan_in,
   // timer unit 0 channels a..d
   input  wire logic [3:0]  timer0_chan_in,
   input  wire logic [3:0]  timer0_chan_oe_in,
   output logic      [3:0]  timer0_chan_out
);

   // =====================================================
   // functions

   // byte-lane merge for 8 and 16 bit writes
   function automatic pin_mux_pkg::reg16_t lane_merge(
      input pin_mux_pkg::reg16_t old_v,
      input logic [15:0]         new_v,
      input logic [1:0]          sel
   );
      pin_mux_pkg::reg16_t r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (sel[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   // data read-back: stored bit when direction 1, pin when 0
   function automatic logic [15:0] read_mix(
      input logic [15:0] stored,
      input logic [15:0] pins,
      input logic [15:0] dir
   );
      return (stored & dir) | (pins & ~dir);
   endfunction

   // word match only: byte lanes 0 and 1 pick the byte inside the low half,
   // so 8 and 16 bit accesses to one register decode alike
   function automatic logic addr_hit(
      input logic [31:0] adr,
      input logic [31:0] base
   );
      return adr[31:2] == base[31:2];
   endfunction

   // =====================================================
   // registers
   pin_mux_pkg::reg16_t porta_data_q;
   pin_mux_pkg::reg16_t portb_sel_q;
   pin_mux_pkg::reg16_t portb_dir_q;
   pin_mux_pkg::reg16_t porta_dir_q;
   logic                ack_q;
   logic [31:0]         rdata_q;

   // bus decode
   logic        req;
   logic        wr_take;
   logic        hit_pa_data;
   logic        hit_pb_sel;
   logic        hit_pb_dir;
   logic        hit_pa_dir;
   logic [15:0] wdata;
   logic [1:0]  wsel;
   logic [15:0] rd_mux;

   // port a views widened to register bit positions
   logic [15:0] pa_pins16;
   logic [15:0] pa_dir16;

   // selector fields
   pin_mux_pkg::pin_mode_e mode0;
   pin_mux_pkg::pin_mode_e mode1;
   pin_mux_pkg::pin_mode_e mode2;
   pin_mux_pkg::pin_mode_e mode3;
   pin_mux_pkg::pin_mode_e mode4;
   pin_mux_pkg::pin_mode_e mode5;

   // =====================================================
   // wishbone decode
   assign req         = wb_cyc_in & wb_stb_in;
   assign wdata       = wb_dat_in[15:0];
   assign wsel        = wb_sel_in[1:0];
   assign hit_pa_data = addr_hit(wb_adr_in, `ADDR_PORTA_DATA);
   assign hit_pb_sel  = addr_hit(wb_adr_in, `ADDR_PORTB_SELECT);
   assign hit_pb_dir  = addr_hit(wb_adr_in, `ADDR_PORTB_DIR);
   assign hit_pa_dir  = addr_hit(wb_adr_in, `ADDR_PORTA_DIR);
   // write lands on the edge where the master sees ack
   assign wr_take     = req & wb_we_in & ack_q;

   // ack one wait state after request, dropped next cycle
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   assign wb_ack_out = ack_q;

   // =====================================================
   // port a data storage, power-on reset only
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         porta_data_q <= `RST_PORTA_DATA;
      end else if (wr_take && hit_pa_data) begin
         // writes always store, whatever the pin function
         porta_data_q <= lane_merge(porta_data_q, wdata, wsel)
                         & `PORTA_DATA_MASK;
      end
   end

   // port b selector fields, all general i/o after reset
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         portb_sel_q <= `RST_PORTB_SELECT;
      end else if (wr_take && hit_pb_sel) begin
         portb_sel_q <= lane_merge(portb_sel_q, wdata, wsel);
      end
   end

   // port b direction
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         portb_dir_q <= `RST_PORTB_DIR;
      end else if (wr_take && hit_pb_dir) begin
         portb_dir_q <= lane_merge(portb_dir_q, wdata, wsel);
      end
   end

   // port a direction, bits 15, 14, 3 held at zero
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         porta_dir_q <= `RST_PORTA_DIR;
      end else if (wr_take && hit_pa_dir) begin
         porta_dir_q <= lane_merge(porta_dir_q, wdata, wsel)
                        & `PORTA_DATA_MASK;
      end
   end

   // =====================================================
   // port a: 14 pins map to bits 15..0 minus 15, 14
   assign pa_pins16 = {2'b00, porta_pin_in};
   assign pa_dir16  = porta_dir_q;

   // read data, unmapped addresses read zero
   always_comb begin
      rd_mux = 16'h0000;
      if (hit_pa_data) begin
         // direction picks stored bit or pin level
         rd_mux = read_mix(porta_data_q, pa_pins16, pa_dir16)
                  & `PORTA_DATA_MASK;
      end else if (hit_pb_sel) begin
         rd_mux = portb_sel_q;
      end else if (hit_pb_dir) begin
         rd_mux = portb_dir_q;
      end else if (hit_pa_dir) begin
         rd_mux = porta_dir_q;
      end
   end

   // read data sampled when the request is first seen
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (req && !ack_q) begin
         rdata_q <= {16'h0000, rd_mux};
      end
   end

   assign wb_dat_out = rdata_q;

   // port a pin drive
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         if (i == `PORTA_CLK_PIN) begin
            // no storage bit here: pin carries the clock
            porta_pin_out[i]    = internal_clock_out_pin_in;
            porta_pin_oe_out[i] = 1'b1;
         end else if (porta_func_in[i]) begin
            // peripheral owns the pin, storage does not reach it
            porta_pin_out[i]    = porta_periph_in[i];
            porta_pin_oe_out[i] = porta_periph_oe_in[i];
         end else begin
            porta_pin_out[i]    = porta_data_q[i];
            porta_pin_oe_out[i] = porta_dir_q[i];
         end
      end
   end

   // peripherals see the live pin level
   assign porta_periph_out = porta_pin_in;

   // =====================================================
   // port b selector fields
   assign mode0 = pin_mux_pkg::pin_mode_e'(portb_sel_q[`SEL_PIN0_LSB +: 2]);
   assign mode1 = pin_mux_pkg::pin_mode_e'(portb_sel_q[`SEL_PIN1_LSB +: 2]);
   assign mode2 = pin_mux_pkg::pin_mode_e'(portb_sel_q[`SEL_PIN2_LSB +: 2]);
   assign mode3 = pin_mux_pkg::pin_mode_e'(portb_sel_q[`SEL_PIN3_LSB +: 2]);
   assign mode4 = pin_mux_pkg::pin_mode_e'(portb_sel_q[`SEL_PIN4_LSB +: 2]);
   assign mode5 = pin_mux_pkg::pin_mode_e'(portb_sel_q[`SEL_PIN5_LSB +: 2]);

   // peripheral inputs read pins only while selected, else 0
   assign serial1_rx_sync_out  = (mode5 == pin_mux_pkg::MODE_ALT2)
                                 & portb_pin_in[5];
   assign uart2_rx_out         = (mode5 == pin_mux_pkg::MODE_ALT3)
                                 & portb_pin_in[5];
   assign serial1_rx_data_out  = (mode4 == pin_mux_pkg::MODE_ALT2)
                                 & portb_pin_in[4];
   assign serial1_tx_clock_out = (mode3 == pin_mux_pkg::MODE_ALT2)
                                 & portb_pin_in[3];
   assign serial1_tx_sync_out  = (mode2 == pin_mux_pkg::MODE_ALT2)
                                 & portb_pin_in[2];
   assign timer0_chan_out[0]   = (mode3 == pin_mux_pkg::MODE_ALT3)
                                 & portb_pin_in[3];
   assign timer0_chan_out[1]   = (mode2 == pin_mux_pkg::MODE_ALT3)
                                 & portb_pin_in[2];
   assign timer0_chan_out[2]   = (mode1 == pin_mux_pkg::MODE_ALT3)
                                 & portb_pin_in[1];
   assign timer0_chan_out[3]   = (mode0 == pin_mux_pkg::MODE_ALT3)
                                 & portb_pin_in[0];

   // port b pin drive; reserved codes leave the pin undriven
   always_comb begin
      // pins 6..15 have no selector here: general i/o
      portb_pin_out    = portb_data_in;
      portb_pin_oe_out = portb_dir_q;
      // pin 5: inputs only in both peripheral modes
      if (mode5 != pin_mux_pkg::MODE_GPIO) begin
         portb_pin_oe_out[5] = 1'b0;
      end
      // pin 4
      unique case (mode4)
         pin_mux_pkg::MODE_GPIO: begin
         end
         pin_mux_pkg::MODE_ALT3: begin
            portb_pin_out[4]    = uart2_tx_in;
            portb_pin_oe_out[4] = 1'b1;
         end
         default: begin
            portb_pin_oe_out[4] = 1'b0;
         end
      endcase
      // pin 3
      unique case (mode3)
         pin_mux_pkg::MODE_GPIO: begin
         end
         pin_mux_pkg::MODE_ALT3: begin
            portb_pin_out[3]    = timer0_chan_in[0];
            portb_pin_oe_out[3] = timer0_chan_oe_in[0];
         end
         default: begin
            portb_pin_oe_out[3] = 1'b0;
         end
      endcase
      // pin 2: both peripheral modes are two-way
      unique case (mode2)
         pin_mux_pkg::MODE_GPIO: begin
         end
         pin_mux_pkg::MODE_ALT2: begin
            portb_pin_out[2]    = serial1_tx_sync_in;
            portb_pin_oe_out[2] = serial1_tx_sync_oe_in;
         end
         pin_mux_pkg::MODE_ALT3: begin
            portb_pin_out[2]    = timer0_chan_in[1];
            portb_pin_oe_out[2] = timer0_chan_oe_in[1];
         end
         default: begin
            portb_pin_oe_out[2] = 1'b0;
         end
      endcase
      // pin 1
      unique case (mode1)
         pin_mux_pkg::MODE_GPIO: begin
         end
         pin_mux_pkg::MODE_ALT2: begin
            portb_pin_out[1]    = serial1_tx_data_in;
            portb_pin_oe_out[1] = 1'b1;
         end
         pin_mux_pkg::MODE_ALT3: begin
            portb_pin_out[1]    = timer0_chan_in[2];
            portb_pin_oe_out[1] = timer0_chan_oe_in[2];
         end
         default: begin
            portb_pin_oe_out[1] = 1'b0;
         end
      endcase
      // pin 0: wake-on-lan sits on code 01 here
      unique case (mode0)
         pin_mux_pkg::MODE_GPIO: begin
         end
         pin_mux_pkg::MODE_ALT1: begin
            portb_pin_out[0]    = wake_on_lan_in;
            portb_pin_oe_out[0] = 1'b1;
         end
         pin_mux_pkg::MODE_ALT3: begin
            portb_pin_out[0]    = timer0_chan_in[3];
            portb_pin_oe_out[0] = timer0_chan_oe_in[3];
         end
         default: begin
            portb_pin_oe_out[0] = 1'b0;
         end
      endcase
   end

endmodule
`default_nettype wire

// [tb/port_pin_mux_and_data_props.sv]
// checker for the port pin mux and data block
// assumes binding to the top module, watching its ports by name
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"
module port_pin_mux_and_data_props (
   // clock, reset and bus
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [31:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   // pins and peripheral taps
   input wire logic [13:0] porta_pin_out,
   input wire logic [13:0] porta_pin_oe_out,
   input wire logic        internal_clock_out_pin_in,
   input wire logic [15:0] portb_pin_in,
   input wire logic [15:0] portb_pin_out,
   input wire logic [15:0] portb_pin_oe_out,
   input wire logic [15:0] portb_data_in,
   input wire logic        serial1_rx_sync_out,
   input wire logic        serial1_tx_clock_out,
   input wire logic        uart2_rx_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // bus timing: one wait state, single-cycle ack
   a_ack_one_wait: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack did not follow request by one cycle");
   a_ack_is_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   a_upper_read_zero: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_resv_bits_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in == `ADDR_PORTA_DATA
      |-> (wb_dat_out & 32'h0000_C008) == 32'h0000_0000)
      else $error("reserved port a bits read nonzero");
   // ==========================================================
   // pin relations
   a_clock_pin_drive: assert property (porta_pin_oe_out[3]
      && porta_pin_out[3] == internal_clock_out_pin_in)
      else $error("clock pin not driven by internal clock");
   a_rx_exclusive: assert property (!(uart2_rx_out && serial1_rx_sync_out))
      else $error("two functions claim pin 5");
   a_rx_follows_pin: assert property (uart2_rx_out || serial1_rx_sync_out
      |-> portb_pin_in[5])
      else $error("pin 5 input not from pin level");
   a_txclk_follows: assert property (serial1_tx_clock_out |-> portb_pin_in[3])
      else $error("pin 3 input not from pin level");
   a_gpio_drive: assert property (((portb_pin_out ^ portb_data_in) & portb_pin_oe_out
      & 16'hFFC0) == 16'h0000)
      else $error("general output pin differs from data");
   a_dir_hold: assert property (!(wb_cyc_in && wb_stb_in && wb_we_in)
      |=> $stable(portb_pin_oe_out[15:6]))
      else $error("direction changed without a write");
endmodule
bind port_pin_mux_and_data port_pin_mux_and_data_props u_props (.mclk_in, .rst_n_in,
   .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .porta_pin_out,
   .porta_pin_oe_out, .internal_clock_out_pin_in, .portb_pin_in, .portb_pin_out,
   .portb_pin_oe_out, .portb_data_in, .serial1_rx_sync_out, .serial1_tx_clock_out,
   .uart2_rx_out);
`default_nettype wire

// [tb/pin_partner.sv]
// external circuitry on the port pins
// assumes the bench sets the level seen on every undriven pin
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   // levels of the outside world
   input  wire logic [13:0] ext_a_in,
   input  wire logic [15:0] ext_b_in,
   // block pin drives
   input  wire logic [13:0] porta_pin_out_in,
   input  wire logic [13:0] porta_pin_oe_in,
   input  wire logic [15:0] portb_pin_out_in,
   input  wire logic [15:0] portb_pin_oe_in,
   // resolved pin levels
   output logic      [13:0] porta_level_out,
   output logic      [15:0] portb_level_out
);
   // ==========================================================
   // a driven pin shows the drive, otherwise the outside level
   assign porta_level_out = (porta_pin_out_in & porta_pin_oe_in)
                          | (ext_a_in & ~porta_pin_oe_in);
   assign portb_level_out = (portb_pin_out_in & portb_pin_oe_in)
                          | (ext_b_in & ~portb_pin_oe_in);
endmodule
`default_nettype wire

// [tb/port_pin_mux_and_data_tb.sv]
// self-checking bench for the port pin mux and data block
// assumes the partner model resolves pins; wishbone master in tasks
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"
module port_pin_mux_and_data_tb;
   // ==========================================================
   // signals
   logic        mclk_in = 0, rst_n_in = 0, ick = 0, pv = 0;
   logic        wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, wb_ack_out;
   logic [31:0] wb_adr_in = 0, wb_dat_in = 0, wb_dat_out, q;
   logic [3:0]  wb_sel_in = 0, timer0_chan_out;
   logic [13:0] ext_a = 0, pa_func = 0, porta_pin_in, porta_pin_out, porta_pin_oe_out, pa_po;
   logic [15:0] ext_b = 0, portb_pin_in, portb_pin_out, portb_pin_oe_out;
   logic        s_rs, s_rd, s_tc, s_ts, u_rx;
   int          n_fail = 0, checked = 0;
   // 40 MHz clock; internal clock pin source toggles each cycle
   always #12.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) ick <= ~ick;
   port_pin_mux_and_data u_dut (.mclk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
      .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .porta_pin_in,
      .porta_pin_out, .porta_pin_oe_out, .porta_func_in(pa_func), .porta_periph_in(14'h1555),
      .porta_periph_oe_in(pa_func), .internal_clock_out_pin_in(ick), .porta_periph_out(pa_po),
      .portb_pin_in, .portb_pin_out, .portb_pin_oe_out,
      .portb_data_in(pv ? 16'h5A5A : 16'hA5A5), .serial1_rx_sync_out(s_rs),
      .serial1_rx_data_out(s_rd), .serial1_tx_clock_out(s_tc), .serial1_tx_sync_in(pv),
      .serial1_tx_sync_oe_in(pv), .serial1_tx_sync_out(s_ts), .serial1_tx_data_in(pv),
      .uart2_rx_out(u_rx), .uart2_tx_in(pv), .wake_on_lan_in(pv), .timer0_chan_in({4{pv}}),
      .timer0_chan_oe_in({4{pv}}), .timer0_chan_out);
   pin_partner u_pins (.ext_a_in(ext_a), .ext_b_in(ext_b), .porta_pin_out_in(porta_pin_out),
      .porta_pin_oe_in(porta_pin_oe_out), .portb_pin_out_in(portb_pin_out),
      .portb_pin_oe_in(portb_pin_oe_out), .porta_level_out(porta_pin_in),
      .portb_level_out(portb_pin_in));
   // ==========================================================
   // reporting
   task automatic conclude();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ==========================================================
   // wishbone classic master: hold until ack, then release
   task automatic wb(input logic we, input logic [31:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge mclk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= we;
      wb_adr_in <= a;
      wb_sel_in <= s;
      wb_dat_in <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk_in);
         if (wb_ack_out === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         conclude();
      end
      r = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      wb_we_in  <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      logic [31:0] r;
      wb(1'b1, a, 4'h3, {16'h0000, d}, r);
   endtask
   task automatic rd(input logic [31:0] a, input logic [15:0] exp);
      logic [31:0] r;
      wb(1'b0, a, 4'h3, 32'h0000_0000, r);
      chk(r, {16'h0000, exp});
   endtask
   // port a read: direction 1 gives stored bit, 0 the pin level
   function automatic logic [15:0] pa_exp(input logic [15:0] dir, input logic [15:0] st);
      return ((dir & st) | (~dir & {2'b00, ext_a})) & `PORTA_DATA_MASK;
   endfunction
   // ==========================================================
   // scenarios
   task automatic do_reset();
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      rst_n_in <= 1'b1;
   endtask
   // every register clear after power-on reset, unmapped reads zero
   task automatic test_reset();
      ext_a <= 14'h0000;
      rd(`ADDR_PORTB_SELECT, 16'h0000);
      rd(`ADDR_PORTB_DIR, 16'h0000);
      rd(`ADDR_PORTA_DIR, 16'h0000);
      rd(32'hFFFF_FCA0, 16'h0000);
      chk(portb_pin_oe_out, 16'h0000);
      wr(`ADDR_PORTA_DIR, 16'h3FFF);
      rd(`ADDR_PORTA_DATA, 16'h0000);
      wr(`ADDR_PORTA_DIR, 16'h0000);
      $display("test reset done");
   endtask
   // every legal selector code, both direction settings, both drive levels
   task automatic test_select();
      logic [15:0] d;
      logic [15:0] w;
      logic [1:0]  c;
      logic [5:0]  g;
      logic [5:0]  oe_x;
      logic [5:0]  out_x;
      for (int k = 0; k < 16; k++) begin
         @(posedge mclk_in);
         d = k[3] ? 16'hFFFF : 16'h0000;
         c = k[1:0];
         pv    <= k[2];
         ext_b <= {16{k[2]}};
         // reserved codes never written: pin 0 stays general under 10
         case (c)
            2'b00: w = 16'h0000;
            2'b01: w = 16'h0001;
            2'b10: w = 16'h0AA8;
            default: w = 16'h0FFF;
         endcase
         // pins still on general i/o for this code
         g = {{5{~c[1]}}, ~c[0]};
         wr(`ADDR_PORTB_DIR, d);
         wr(`ADDR_PORTB_SELECT, w);
         #1;
         case (c)
            2'b00: oe_x = d[5:0];
            2'b01: oe_x = {d[5:1], 1'b1};
            2'b10: oe_x = {3'b000, pv, 1'b1, d[0]};
            default: oe_x = {2'b01, {4{pv}}};
         endcase
         out_x = ((pv ? 6'h1A : 6'h25) & g) | ({6{pv}} & ~g);
         chk(portb_pin_oe_out, {d[15:6], oe_x});
         chk(portb_pin_out[5:0] & oe_x, out_x & oe_x);
         chk({u_rx, s_rs, s_rd, s_tc, s_ts, timer0_chan_out},
             {c == 2'b11 && pv, {4{c == 2'b10 && pv}}, {4{c == 2'b11 && pv}}});
      end
      rd(`ADDR_PORTB_SELECT, 16'h0FFF);
      rd(`ADDR_PORTB_DIR, 16'hFFFF);
      $display("test select done");
   endtask
   // port a data by direction and function, byte lane write
   task automatic test_porta();
      ext_a <= 14'h2A55;
      wr(`ADDR_PORTA_DIR, 16'h00FF);
      rd(`ADDR_PORTA_DIR, 16'h00F7);
      wr(`ADDR_PORTA_DATA, 16'h3FF7);
      #1;
      chk(porta_pin_oe_out, 14'h00FF);
      chk(porta_pin_out & 14'h00F7, 14'h00F7);
      rd(`ADDR_PORTA_DATA, pa_exp(16'h00F7, 16'h3FF7));
      wb(1'b1, `ADDR_PORTA_DATA, 4'h1, 32'h0000_0000, q);
      rd(`ADDR_PORTA_DATA, pa_exp(16'h00F7, 16'h3F00));
      // peripherals own every pin but clock pin 3 and drive 1555; storage must not leak out
      pa_func <= 14'h3FFF;
      wr(`ADDR_PORTA_DATA, 16'h00F7);
      #1;
      chk(porta_pin_oe_out, 14'h3FFF);
      chk(porta_pin_out & 14'h3FF7, 14'h1555);
      chk(pa_po, {10'h155, ick, 3'b101});
      rd(`ADDR_PORTA_DATA, 16'h15F7);
      pa_func <= 14'h0000;
      #1;
      chk(porta_pin_out & 14'h00F7, 14'h00F7);
      $display("test porta done");
   endtask
   // ==========================================================
   // main sequence, with a second reset in mid-run
   initial begin
      do_reset();
      test_reset();
      test_select();
      test_porta();
      do_reset();
      test_reset();
      conclude();
   end
endmodule
`default_nettype wire
